// ==== verilog/xpt_pkg.sv ====
// Constants, field layout and register map of the serial crosspoint configuration loader.
// Assumes a single core clock; serial pins arrive synchronous to that clock.
package xpt_pkg;

    localparam int NUM_OUT = 32;
    localparam int NUM_IN = 32;
    localparam int SEL_W = 5;
    localparam int CH_W = 6;
    localparam int EN_POS = 5;
    localparam int WORD_BITS = 1 + NUM_OUT * CH_W;
    localparam int CLAMP_POS = WORD_BITS - 1;
    localparam int IDX_W = 5;
    localparam int BIT_CNT_W = 16;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h000;
    localparam logic [ADDR_W-1:0] OVERLAY_MASK_ADDR = 12'h004;
    localparam logic [ADDR_W-1:0] BIT_COUNT_ADDR = 12'h008;
    localparam logic [ADDR_W-1:0] ROUTE_BASE_ADDR = 12'h080;
    localparam int ROUTE_IDX_LSB = 2;
    localparam int ROUTE_IDX_MSB = 6;
    localparam int ROUTE_BLOCK_LSB = 7;

    localparam int ST_CLAMP_BIT = 0;
    localparam int ST_SELECTED_BIT = 1;
    localparam int ST_TRANSPARENT_BIT = 2;
    localparam int ST_WORD_DONE_BIT = 3;

    localparam logic [DATA_W-1:0] OVERLAY_MASK_RESET = 32'hFFFFFFFF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_FETCH = 2'b01,
        RD_RESP = 2'b10
    } rd_state_t;

endpackage

// ==== verilog/route_latch_bank.sv ====
// Second-rank route store: one enable-plus-select word per output, all visible in parallel.
// Assumes the caller decides when the bank is transparent and when it is cleared.
`timescale 1ns/1ps
module route_latch_bank #(
    parameter int NUM_CH = 32,
    parameter int CH_W = 6,
    parameter int IDX_W = 5
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Control
    input wire logic clear,
    input wire logic load,
    input wire logic [NUM_CH*CH_W-1:0] loadData,
    // Parallel view
    output logic [NUM_CH*CH_W-1:0] route,
    // Read port
    input wire logic [IDX_W-1:0] rdIndex,
    output logic [CH_W-1:0] rdData
);

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            always_ff @(posedge core_clk) begin
                if (rst || clear) begin
                    route[ch*CH_W +: CH_W] <= '0;
                end else if (load) begin
                    route[ch*CH_W +: CH_W] <= loadData[ch*CH_W +: CH_W];
                end
            end
        end
    endgenerate

    // The read path is registered so software reads never lengthen the decode path.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdData <= '0;
        end else begin
            rdData <= route[rdIndex*CH_W +: CH_W];
        end
    end

endmodule

// ==== verilog/crosspoint_serial_config.sv ====
// Control logic of a 32 by 32 crosspoint: serial loader, two ranks, decode and overlay muxes.
// Assumes serial pins are synchronous to core_clk and the serial clock is much slower.
`timescale 1ns/1ps
module crosspoint_serial_config #(
    parameter int SAMPLE_W = 10
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Serial programming pins
    input wire logic chipSelect_n,
    input wire logic serialClk,
    input wire logic serialDataIn,
    input wire logic update_n,
    input wire logic configReset_n,
    output logic serialDataOut,
    // Video path
    input wire logic [xpt_pkg::NUM_IN*SAMPLE_W-1:0] matrixInput,
    input wire logic [xpt_pkg::NUM_OUT*SAMPLE_W-1:0] overlayInput,
    input wire logic [xpt_pkg::NUM_OUT-1:0] overlaySelect,
    output logic [xpt_pkg::NUM_OUT*SAMPLE_W-1:0] videoOut,
    output logic [xpt_pkg::NUM_OUT-1:0] videoOutEn,
    output logic [xpt_pkg::NUM_OUT*xpt_pkg::NUM_IN-1:0] stageEnable,
    output logic clampEnable,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [xpt_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [xpt_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [xpt_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [xpt_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);
    import xpt_pkg::*;

    logic serialClkPrev;
    logic clkRise;
    logic chipSelectPrev_n;
    logic selectStart;
    logic [WORD_BITS-1:0] firstRank;
    logic rankLoad;
    logic rankClear;
    logic [NUM_OUT*CH_W-1:0] route;
    logic [CH_W-1:0] bankRdData;
    logic [IDX_W-1:0] bankRdIndex;
    logic [BIT_CNT_W-1:0] bitCount;
    logic [DATA_W-1:0] overlayMask;

    logic awHeld;
    logic wHeld;
    logic [ADDR_W-1:0] awAddr;
    logic [DATA_W-1:0] wData;
    logic [3:0] wStrb;
    logic writeFire;
    logic writeMapped;

    rd_state_t rdState;
    rd_state_t next_rdState;
    logic [ADDR_W-1:0] arAddr;
    logic [DATA_W-1:0] next_rdata;
    logic next_rdMapped;

    function automatic logic isRoute(input logic [ADDR_W-1:0] addr);
        return addr[ADDR_W-1:ROUTE_BLOCK_LSB] == ROUTE_BASE_ADDR[ADDR_W-1:ROUTE_BLOCK_LSB];
    endfunction

    function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] word;
        word = {addr[ADDR_W-1:2], 2'b00};
        return word == STATUS_ADDR || word == OVERLAY_MASK_ADDR
            || word == BIT_COUNT_ADDR || isRoute(addr);
    endfunction

    // Serial clock edge seen in the core domain; the pin is already synchronous.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            serialClkPrev <= 1'b0;
            chipSelectPrev_n <= 1'b1;
        end else begin
            serialClkPrev <= serialClk;
            chipSelectPrev_n <= chipSelect_n;
        end
    end

    assign clkRise = serialClk & ~serialClkPrev;
    assign selectStart = chipSelectPrev_n & ~chipSelect_n;

    // First rank: the newest bit enters at bit 0, so the first bit sent ends at the top.
    always_ff @(posedge core_clk) begin
        if (rst || !configReset_n) begin
            firstRank <= '0;
        end else if (!chipSelect_n && clkRise) begin
            firstRank <= {firstRank[WORD_BITS-2:0], serialDataIn};
        end
    end

    // The top stage is the bit shifted in 192 clocks earlier, ready for the next device.
    assign serialDataOut = firstRank[CLAMP_POS];

    // Update low with chip select low behaves as a transparent latch: rank two follows rank one every cycle.
    // A controller that leaves update low while shifting will see every intermediate state.
    assign rankLoad = !chipSelect_n && !update_n;
    assign rankClear = !configReset_n;

    always_ff @(posedge core_clk) begin
        if (rst || rankClear) begin
            clampEnable <= 1'b0;
        end else if (rankLoad) begin
            clampEnable <= firstRank[CLAMP_POS];
        end
    end

    route_latch_bank #(
        .NUM_CH(NUM_OUT),
        .CH_W(CH_W),
        .IDX_W(IDX_W)
    ) u_bank (
        .core_clk(core_clk),
        .rst(rst),
        .clear(rankClear),
        .load(rankLoad),
        .loadData(firstRank[NUM_OUT*CH_W-1:0]),
        .route(route),
        .rdIndex(bankRdIndex),
        .rdData(bankRdData)
    );

    // Per-output decode and overlay mux; every output decodes on its own, so
    // several outputs may name the same input.
    genvar k;
    generate
        for (k = 0; k < NUM_OUT; k++) begin : g_out
            logic chEnable;
            logic [SEL_W-1:0] chSelect;
            logic [SAMPLE_W-1:0] chSample;
            logic overlayActive;

            assign chEnable = route[k*CH_W + EN_POS];
            assign chSelect = route[k*CH_W +: SEL_W];
            assign stageEnable[k*NUM_IN +: NUM_IN] =
                chEnable ? (NUM_IN'(1) << chSelect) : '0;
            assign chSample = matrixInput[chSelect*SAMPLE_W +: SAMPLE_W];
            assign overlayActive = overlaySelect[k] & overlayMask[k];
            assign videoOutEn[k] = chEnable;
            always_comb begin
                if (!chEnable) begin
                    videoOut[k*SAMPLE_W +: SAMPLE_W] = '0;
                end else if (overlayActive) begin
                    videoOut[k*SAMPLE_W +: SAMPLE_W] = overlayInput[k*SAMPLE_W +: SAMPLE_W];
                end else begin
                    videoOut[k*SAMPLE_W +: SAMPLE_W] = chSample;
                end
            end
        end
    endgenerate

    // Bits shifted since chip select fell; saturates rather than wrapping.
    // A shift taken at the very edge that sees the select fall is the first bit.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bitCount <= '0;
        end else if (selectStart) begin
            bitCount <= BIT_CNT_W'(clkRise);
        end else if (!chipSelect_n && clkRise && bitCount != '1) begin
            bitCount <= bitCount + BIT_CNT_W'(1);
        end
    end

    // Write channel: address and data are held separately, in either order.
    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready = !wHeld && !s_axi_bvalid;
    assign writeFire = awHeld && wHeld && !s_axi_bvalid;
    assign writeMapped = isMapped(awAddr);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            awHeld <= 1'b0;
            awAddr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
        end else if (writeFire) begin
            awHeld <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wHeld <= 1'b0;
            wData <= '0;
            wStrb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
        end else if (writeFire) begin
            wHeld <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (writeFire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= writeMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Only the overlay mask is writable; other mapped words ignore writes.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            overlayMask <= OVERLAY_MASK_RESET;
        end else if (writeFire && {awAddr[ADDR_W-1:2], 2'b00} == OVERLAY_MASK_ADDR) begin
            for (int b = 0; b < 4; b++) begin
                if (wStrb[b]) begin
                    overlayMask[b*8 +: 8] <= wData[b*8 +: 8];
                end
            end
        end
    end

    // Read channel: the bank is addressed straight from araddr, so its registered
    // word is ready in the fetch cycle.
    assign s_axi_arready = (rdState == RD_IDLE);
    assign bankRdIndex = s_axi_araddr[ROUTE_IDX_MSB:ROUTE_IDX_LSB];

    always_comb begin
        next_rdState = rdState;
        case (rdState)
            RD_IDLE: begin
                if (s_axi_arvalid) begin
                    next_rdState = RD_FETCH;
                end
            end
            RD_FETCH: begin
                next_rdState = RD_RESP;
            end
            RD_RESP: begin
                if (s_axi_rready) begin
                    next_rdState = RD_IDLE;
                end
            end
            default: begin
                next_rdState = RD_IDLE;
            end
        endcase
    end

    always_comb begin
        next_rdata = '0;
        next_rdMapped = 1'b1;
        if (isRoute(arAddr)) begin
            next_rdata[CH_W-1:0] = bankRdData;
        end else begin
            case ({arAddr[ADDR_W-1:2], 2'b00})
                STATUS_ADDR: begin
                    next_rdata[ST_CLAMP_BIT] = clampEnable;
                    next_rdata[ST_SELECTED_BIT] = !chipSelect_n;
                    next_rdata[ST_TRANSPARENT_BIT] = rankLoad;
                    next_rdata[ST_WORD_DONE_BIT] = (bitCount >= BIT_CNT_W'(WORD_BITS));
                end
                OVERLAY_MASK_ADDR: begin
                    next_rdata = overlayMask;
                end
                BIT_COUNT_ADDR: begin
                    next_rdata[BIT_CNT_W-1:0] = bitCount;
                end
                default: begin
                    next_rdMapped = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdState <= RD_IDLE;
            arAddr <= '0;
        end else begin
            rdState <= next_rdState;
            if (s_axi_arvalid && s_axi_arready) begin
                arAddr <= s_axi_araddr;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (rdState == RD_FETCH) begin
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rdMapped ? RESP_OKAY : RESP_SLVERR;
        end
    end

    assign s_axi_rvalid = (rdState == RD_RESP);

endmodule

// ==== bench/xpt_port_monitor.sv ====
// Concurrent checks on the crosspoint loader's top-level ports.
// Assumes it is bound onto every crosspoint_serial_config instance.
`timescale 1ns/1ps
module xpt_port_monitor #(
    parameter int SAMPLE_W = 10
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Serial pins
    input wire logic chipSelect_n,
    input wire logic serialClk,
    input wire logic update_n,
    input wire logic configReset_n,
    input wire logic serialDataOut,
    // Video path
    input wire logic [xpt_pkg::NUM_OUT*SAMPLE_W-1:0] videoOut,
    input wire logic [xpt_pkg::NUM_OUT-1:0] videoOutEn,
    input wire logic [xpt_pkg::NUM_OUT*xpt_pkg::NUM_IN-1:0] stageEnable,
    input wire logic clampEnable
);
    import xpt_pkg::*;
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (rst);
    sel_freeze_a: assert property (chipSelect_n && configReset_n |=>
        $stable(serialDataOut) && $stable(videoOutEn) && $stable(clampEnable))
        else $error("state moved while deselected");
    reset_clear_a: assert property (!configReset_n |=> videoOutEn == '0
        && stageEnable == '0 && !clampEnable && !serialDataOut)
        else $error("config reset left state behind");
    blank_out_a: assert property (!videoOutEn[0] |-> videoOut[SAMPLE_W-1:0] == '0)
        else $error("disabled output carries a sample");
    one_stage_a: assert property ($onehot0(stageEnable[31:0])
        && $onehot0(stageEnable[1023 -: 32]))
        else $error("more than one stage drives an output");
    stage_en_a: assert property (videoOutEn[31] == |stageEnable[1023 -: 32])
        else $error("enable and stage select disagree");
    shift_only_a: assert property ($changed(serialDataOut) |-> $past(!configReset_n)
        || $past(!chipSelect_n && serialClk) && !$past(serialClk, 2))
        else $error("serial output moved without a shift");
    clamp_only_a: assert property ($changed(clampEnable) |->
        $past(!configReset_n || !chipSelect_n && !update_n))
        else $error("clamp moved without an update");
    hold_rank_a: assert property (update_n && configReset_n |=>
        $stable(videoOutEn) && $stable(stageEnable))
        else $error("switch state moved without an update");
endmodule

bind crosspoint_serial_config xpt_port_monitor #(.SAMPLE_W(SAMPLE_W)) mon (
    .core_clk(core_clk), .rst(rst), .chipSelect_n(chipSelect_n), .serialClk(serialClk),
    .update_n(update_n), .configReset_n(configReset_n), .serialDataOut(serialDataOut),
    .videoOut(videoOut), .videoOutEn(videoOutEn), .stageEnable(stageEnable),
    .clampEnable(clampEnable));

// ==== bench/serial_host.sv ====
// Behavioural host controller driving the serial programming pins.
// Assumes one core clock; every pin changes right after a rising edge.
`timescale 1ns/1ps
module serial_host (
    // Clock
    input wire logic core_clk,
    // Serial programming pins
    output logic chipSelect_n,
    output logic serialClk,
    output logic serialDataIn,
    output logic update_n
);
    initial begin
        chipSelect_n = 1'b1;
        serialClk = 1'b0;
        serialDataIn = 1'b0;
        update_n = 1'b1;
    end
    // Sends the top n bits of v, top bit first; the clock stands low between bits.
    task automatic shift_bits(input logic [192:0] v, input int n, input logic csLow);
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk);
            chipSelect_n <= !csLow;
            update_n <= 1'b1;
            serialClk <= 1'b1;
            serialDataIn <= v[192-i];
            @(posedge core_clk);
            serialClk <= 1'b0;
            // Data is only held while the clock is high, so show the inverse after.
            serialDataIn <= !v[192-i];
        end
        // The last shift lands at the edge above; let it settle before the caller looks.
        @(posedge core_clk);
    endtask
    task automatic pulse_update(input logic csLow);
        @(posedge core_clk);
        chipSelect_n <= !csLow;
        update_n <= 1'b0;
        @(posedge core_clk);
        update_n <= 1'b1;
        @(posedge core_clk);
        chipSelect_n <= 1'b1;
    endtask
endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench: serial host, register bus and video path of the loader.
// Assumes the package, the loader, the host model and the port monitor are compiled first.
`timescale 1ns/1ps
module tb_top;
    import xpt_pkg::*;
    localparam int SW = 10;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic configReset_n = 1'b1;
    logic chipSelect_n, serialClk, serialDataIn, update_n, serialDataOut, clampEnable;
    logic [NUM_IN*SW-1:0] matrixInput;
    logic [NUM_OUT*SW-1:0] overlayInput, videoOut;
    logic [NUM_OUT-1:0] overlaySelect = '0;
    logic [NUM_OUT-1:0] videoOutEn;
    logic [NUM_OUT*NUM_IN-1:0] stageEnable;
    logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
    logic arvalid = 0, arready, rvalid, rready = 0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = '0;
    logic [1:0] bresp, rresp;
    logic [31:0] mask = 32'hFFFFFFFF;
    logic [192:0] w;
    int nMismatch = 0;
    int totalChecks = 0;
    always #4 core_clk = ~core_clk;
    serial_host host (.core_clk(core_clk), .chipSelect_n(chipSelect_n), .serialClk(serialClk),
        .serialDataIn(serialDataIn), .update_n(update_n));
    crosspoint_serial_config #(.SAMPLE_W(SW)) uut (.core_clk(core_clk), .rst(rst),
        .chipSelect_n(chipSelect_n), .serialClk(serialClk), .serialDataIn(serialDataIn),
        .update_n(update_n), .configReset_n(configReset_n), .serialDataOut(serialDataOut),
        .matrixInput(matrixInput), .overlayInput(overlayInput), .overlaySelect(overlaySelect),
        .videoOut(videoOut), .videoOutEn(videoOutEn), .stageEnable(stageEnable),
        .clampEnable(clampEnable), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp));
    task automatic chk(input logic [1023:0] got, input logic [1023:0] exp);
        totalChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
            input logic [1:0] er);
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (awvalid && !awready || wvalid && !wready);
        do @(posedge core_clk); while (!bvalid);
        bready <= 1'b0;
        chk(1024'(bresp), 1024'(er));
    endtask
    task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge core_clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge core_clk); while (!rvalid);
        rready <= 1'b0;
        chk(1024'(rdata), 1024'(ed));
        chk(1024'(rresp), 1024'(er));
    endtask
    // Expected switch state worked out from a programmed word and the overlay pins.
    task automatic chk_state(input logic [192:0] v);
        logic [1023:0] st;
        logic [NUM_OUT*SW-1:0] vid;
        logic [NUM_OUT-1:0] en;
        st = '0;
        vid = '0;
        for (int k = 0; k < NUM_OUT; k++) begin
            en[k] = v[k*CH_W+EN_POS];
            if (en[k]) begin
                st[k*NUM_IN+v[k*CH_W +: SEL_W]] = 1'b1;
                vid[k*SW +: SW] = (overlaySelect[k] && mask[k]) ? overlayInput[k*SW +: SW]
                    : matrixInput[v[k*CH_W +: SEL_W]*SW +: SW];
            end
        end
        chk(1024'(videoOutEn), 1024'(en));
        chk(stageEnable, st);
        chk(1024'(videoOut), 1024'(vid));
        chk(1024'(clampEnable), 1024'(v[CLAMP_POS]));
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", totalChecks, nMismatch);
        if (nMismatch == 0 && totalChecks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Three words of about 400 cycles each are expected; 20000 cycles, over sixteen times that, means a hang.
    initial begin
        repeat (20000) @(posedge core_clk);
        nMismatch++;
        report_and_stop();
    end
    initial begin
        for (int k = 0; k < NUM_IN; k++) begin
            matrixInput[k*SW +: SW] = SW'(k*3+1);
            overlayInput[k*SW +: SW] = SW'(1000-k);
        end
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        chk_state('0);
        axi_rd(OVERLAY_MASK_ADDR, 32'hFFFFFFFF, RESP_OKAY);
        axi_rd(12'h00C, 32'h00000000, RESP_SLVERR);
        axi_wr(12'h010, 32'h00000001, 4'hF, RESP_SLVERR);
        for (int k = 0; k < NUM_OUT; k++)
            w[k*CH_W +: CH_W] = {1'b1, 5'(31-k)};
        w[CLAMP_POS] = 1'b1;
        host.shift_bits(w, WORD_BITS, 1'b1);
        chk_state('0);
        chk(1024'(serialDataOut), 1024'(w[CLAMP_POS]));
        axi_rd(BIT_COUNT_ADDR, 32'h000000C1, RESP_OKAY);
        axi_rd(STATUS_ADDR, 32'h0000000A, RESP_OKAY);
        host.pulse_update(1'b1);
        chk_state(w);
        w = '0;
        w[0 +: CH_W] = 6'h25;
        w[CH_W +: CH_W] = 6'h07;
        w[31*CH_W +: CH_W] = 6'h25;
        host.shift_bits(w, WORD_BITS, 1'b1);
        chk(1024'(serialDataOut), 1024'(w[CLAMP_POS]));
        host.pulse_update(1'b1);
        chk_state(w);
        axi_rd(ROUTE_BASE_ADDR + 12'h004, 32'h00000007, RESP_OKAY);
        overlaySelect <= 32'h80000003;
        @(posedge core_clk);
        chk_state(w);
        mask = 32'hFFFFFFFE;
        axi_wr(OVERLAY_MASK_ADDR, 32'h000000FE, 4'h1, RESP_OKAY);
        axi_rd(OVERLAY_MASK_ADDR, mask, RESP_OKAY);
        chk_state(w);
        host.shift_bits(~w, WORD_BITS, 1'b0);
        host.pulse_update(1'b0);
        chk_state(w);
        chk(1024'(serialDataOut), 1024'(w[CLAMP_POS]));
        configReset_n <= 1'b0;
        @(posedge core_clk);
        configReset_n <= 1'b1;
        @(posedge core_clk);
        chk_state('0);
        chk(1024'(serialDataOut), 1024'(1'b0));
        report_and_stop();
    end
endmodule
